//--- logic/eep_engine.sv
// read and write command engine of a 64 Kbyte serial eeprom on a two-wire bus
// assumes an open-drain data line resolved outside, the host clocking the bus, and straps tied
//
// Contract
// - one array byte is selected by a 16-bit word address, data are 8 bits
// - byte write: addresses and data acknowledged; host stop starts programming
// - while programming, every bus input is ignored and nothing answers
// - page write programs up to 128 bytes of one row; partial pages allowed
// - up to 127 more bytes follow the first; each acknowledged; stop starts programming
// - each written byte increments only the low seven address bits, wrapping in page
// - polling bytes get no acknowledge while programming; acknowledged once finished
// - programming from stop to first acknowledged start stays within the cycle bound
// - write-protect high blocks all writes; low leaves the array writable
// - write-protect is sampled at the stop; later changes do not touch programming
// - protected writes are still acknowledged; stop starts nothing, ready at once
// - address counter holds last accessed address plus one, kept between operations
// - reading past the last byte wraps the counter to address zero
// - read device byte is acknowledged, then the byte at the counter is shifted out
// - host ends a read with no-acknowledge on the ninth clock, then stop or start
// - host acknowledge advances the address and sends the next byte, wrapping at top
// - array content starts as all ones in every byte
// - device byte: type code in 7..4, straps matched in 3..1, direction in 0
// - first address byte carries bits 15..8, second bits 7..0, both acknowledged
// - acknowledge holds data low through the ninth clock after the line is released
`timescale 1ns/1ns
module eep_engine import eep_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // serial bus
  input wire logic LINK_SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // straps and protection
  input wire logic WP,
  input wire logic CLIENT_SELECT_BIT2,
  input wire logic CLIENT_SELECT_BIT1,
  input wire logic CLIENT_SELECT_BIT0,
  // status
  output logic PROG_BUSY
);

  eep_line_ev_t ev;
  eep_state_t state_ff;
  eep_state_t nxt_state;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic wp_s;
  logic [2:0] sel_s;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [6:0] sh_ff;
  logic [DATA_W-1:0] byte_in;
  logic byte_done;
  logic ack_bit;
  logic ack_ff;
  logic nxt_ack;
  logic tx_mode_ff;
  logic nxt_tx_mode;
  logic [DATA_W-1:0] tx_ff;
  logic [DATA_W-1:0] nxt_tx;
  logic [2:0] tx_idx;
  logic [ADDR_W-1:0] cur_addr_ff;
  logic [ADDR_W-1:0] nxt_cur_addr;
  logic [DATA_W-1:0] addr_hi_ff;
  logic [DATA_W-1:0] nxt_addr_hi;
  logic [DATA_W-1:0] arr_q;
  logic [DATA_W-1:0] pb_q;
  logic pb_we;
  logic pb_clear;
  logic [PAGE_BYTES-1:0] valid_ff;
  logic busy_ff;
  logic prog_go;
  logic prog_end;
  logic [31:0] prog_cnt_ff;
  logic [PAGE_AW:0] cm_idx_ff;
  logic cm_we_ff;
  logic [PAGE_AW-1:0] cm_wr_idx_ff;

  eep_link_rx u_link (
    .core_clk(CORE_CLK),
    .sys_rst(SYS_RST),
    .link_scl(LINK_SCL),
    .sda_in(SDA_IN),
    .line_ev(ev)
  );

  // strap and protect pins come from outside, so they pass two flops first
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
    end else begin
      pin_s1_ff <= {WP, CLIENT_SELECT_BIT2, CLIENT_SELECT_BIT1, CLIENT_SELECT_BIT0};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign wp_s = pin_s2_ff[3];
  assign sel_s = pin_s2_ff[2:0];

  // byte assembly and the two clocks that matter within a byte
  assign byte_in = {sh_ff, ev.bit_val};
  assign byte_done = ev.bit_ev && (cnt_ff == BIT_LAST_DATA);
  assign ack_bit = ev.bit_ev && (cnt_ff == BIT_ACK);
  assign tx_idx = BYTE_MSB - cnt_ff[2:0];

  // protocol decode: what each finished byte and each host acknowledge does
  always_comb begin
    nxt_state = state_ff;
    nxt_ack = ack_ff;
    nxt_tx_mode = tx_mode_ff;
    nxt_tx = tx_ff;
    nxt_cur_addr = cur_addr_ff;
    nxt_addr_hi = addr_hi_ff;
    pb_we = 1'h0;
    pb_clear = 1'h0;
    nxt_cnt = cnt_ff;
    if (ev.bit_ev) begin
      nxt_cnt = (cnt_ff == BIT_ACK) ? BIT_FIRST : 4'(cnt_ff + 4'h1);
    end
    if (ev.start) begin
      // a restart abandons any unfinished page load
      nxt_state = ST_DEVADDR;
      nxt_cnt = BIT_FIRST;
      nxt_ack = 1'h0;
      nxt_tx_mode = 1'h0;
      // never while programming: the commit walk still reads the byte marks
      pb_clear = !busy_ff;
    end else if (ev.stop) begin
      nxt_state = ST_IDLE;
      nxt_cnt = BIT_FIRST;
      nxt_ack = 1'h0;
      nxt_tx_mode = 1'h0;
    end else if (byte_done) begin
      nxt_ack = 1'h0;
      unique case (state_ff)
        ST_DEVADDR: begin
          // programming in progress: stay silent, polling included
          if (!busy_ff && byte_in[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE
              && byte_in[DEV_SEL_MSB:DEV_SEL_LSB] == sel_s) begin
            nxt_ack = 1'h1;
            if (byte_in[DEV_DIR_BIT] == DIR_READ) begin
              // current byte goes out, counter moves past it
              nxt_state = ST_RDATA;
              nxt_tx = arr_q;
              nxt_tx_mode = 1'h1;
              nxt_cur_addr = 16'(cur_addr_ff + 16'h1);
            end else begin
              nxt_state = ST_ADDR_HI;
            end
          end else begin
            nxt_state = ST_IGNORE;
          end
        end
        ST_ADDR_HI: begin
          nxt_addr_hi = byte_in;
          nxt_ack = 1'h1;
          nxt_state = ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          // the counter is loaded here, so a stop now still leaves it set
          nxt_cur_addr = {addr_hi_ff, byte_in};
          nxt_ack = 1'h1;
          nxt_state = ST_WDATA;
          pb_clear = 1'h1;
        end
        ST_WDATA: begin
          // data acknowledged even when protected; low seven bits wrap in the page
          pb_we = 1'h1;
          nxt_ack = 1'h1;
          nxt_cur_addr = {cur_addr_ff[ADDR_W-1:PAGE_AW],
                          7'(cur_addr_ff[PAGE_AW-1:0] + 7'h1)};
        end
        ST_RDATA: begin
          // device was the sender, so its ninth clock belongs to the host
          nxt_ack = 1'h0;
        end
        ST_IDLE, ST_IGNORE: begin
          nxt_state = state_ff;
        end
      endcase
    end else if (ack_bit && state_ff == ST_RDATA && !ack_ff) begin
      // the ninth clock of the device byte carries our own acknowledge, not the host's
      if (!ev.bit_val) begin
        // host acknowledged: next byte, full-range wrap
        nxt_tx = arr_q;
        nxt_cur_addr = 16'(cur_addr_ff + 16'h1);
      end else begin
        // no-acknowledge ends the read; wait for stop or start
        nxt_tx_mode = 1'h0;
        nxt_state = ST_IGNORE;
      end
    end
  end

  // protocol state
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_ff <= ST_IDLE;
      cnt_ff <= BIT_FIRST;
      ack_ff <= 1'h0;
      tx_mode_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ack_ff <= nxt_ack;
      tx_mode_ff <= nxt_tx_mode;
    end
  end

  // data path registers; the counter keeps its value across transactions
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sh_ff <= 7'h0;
      tx_ff <= ERASED_BYTE;
      addr_hi_ff <= 8'h0;
      cur_addr_ff <= 16'h0;
    end else begin
      if (ev.bit_ev) begin
        sh_ff <= byte_in[6:0];
      end
      tx_ff <= nxt_tx;
      addr_hi_ff <= nxt_addr_hi;
      cur_addr_ff <= nxt_cur_addr;
    end
  end

  // line driver changes on falling clock; the device only ever pulls low
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SDA_OE_N <= 1'h1;
    end else if (ev.start || ev.stop) begin
      SDA_OE_N <= 1'h1;
    end else if (ev.scl_fall) begin
      if (cnt_ff == BIT_ACK) begin
        SDA_OE_N <= ~ack_ff;
      end else if (tx_mode_ff) begin
        SDA_OE_N <= tx_ff[tx_idx];
      end else begin
        SDA_OE_N <= 1'h1;
      end
    end
  end

  assign SDA_OUT = 1'h0;

  // received page bytes are marked so only they get committed
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      valid_ff <= '0;
    end else if (pb_we) begin
      valid_ff[cur_addr_ff[PAGE_AW-1:0]] <= 1'h1;
    end else if (pb_clear || prog_end) begin
      valid_ff <= '0;
    end
  end

  // stop after data starts programming unless protect is high at that moment
  assign prog_go = ev.stop && state_ff == ST_WDATA && (|valid_ff) && !busy_ff
                   && !wp_s;
  assign prog_end = busy_ff && (prog_cnt_ff == 32'(PROG_CYCLES - 1));
  assign PROG_BUSY = busy_ff;

  // self-timed cycle; protect is not looked at again once it runs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      busy_ff <= 1'h0;
      prog_cnt_ff <= 32'h0;
    end else if (prog_go) begin
      busy_ff <= 1'h1;
      prog_cnt_ff <= 32'h0;
    end else if (busy_ff) begin
      busy_ff <= !prog_end;
      prog_cnt_ff <= 32'(prog_cnt_ff + 32'h1);
    end
  end

  // commit walks the page buffer during the cycle; one byte per clock, buffer read is registered
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cm_idx_ff <= '0;
      cm_we_ff <= 1'h0;
      cm_wr_idx_ff <= '0;
    end else begin
      if (prog_go) begin
        cm_idx_ff <= '0;
      end else if (busy_ff && !cm_idx_ff[PAGE_AW]) begin
        cm_idx_ff <= (PAGE_AW + 1)'(cm_idx_ff + 1'h1);
      end
      cm_we_ff <= busy_ff && !cm_idx_ff[PAGE_AW] && valid_ff[cm_idx_ff[PAGE_AW-1:0]];
      cm_wr_idx_ff <= cm_idx_ff[PAGE_AW-1:0];
    end
  end

  // page buffer: loaded from the bus, drained by the commit walk
  eep_mem #(.AW(PAGE_AW), .DW(DATA_W), .INIT(ERASED_BYTE)) u_page (
    .clk(CORE_CLK),
    .we(pb_we),
    .waddr(cur_addr_ff[PAGE_AW-1:0]),
    .wdata(byte_in),
    .raddr(cm_idx_ff[PAGE_AW-1:0]),
    .rdata(pb_q)
  );

  // main array, all ones from the start; row comes from the frozen address counter
  eep_mem #(.AW(ADDR_W), .DW(DATA_W), .INIT(ERASED_BYTE)) u_array (
    .clk(CORE_CLK),
    .we(cm_we_ff),
    .waddr({cur_addr_ff[ADDR_W-1:PAGE_AW], cm_wr_idx_ff}),
    .wdata(pb_q),
    .raddr(cur_addr_ff),
    .rdata(arr_q)
  );

endmodule

//--- logic/eep_pkg.sv
// shared constants, field layout, states and carriers of the serial eeprom engine
// assumes a 100 MHz core clock and a host-driven serial clock on its own port
package eep_pkg;

  // array geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PAGE_AW = 7;
  localparam int ROW_W = ADDR_W - PAGE_AW;
  localparam int PAGE_BYTES = 1 << PAGE_AW;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  // device address byte layout
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_DIR_BIT = 0;
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam logic DIR_READ = 1'h1;

  // bit counter within one byte plus its acknowledge clock
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [2:0] BYTE_MSB = 3'h7;

  // programming time, the cycle count rounds down as a longest time
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_TIME_NS = PROG_TIME_MS * 1000000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

  // line events seen in the core domain
  typedef struct packed {
    logic start;
    logic stop;
    logic bit_ev;
    logic bit_val;
    logic scl_fall;
  } eep_line_ev_t;

  // protocol states, gray along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ADDR_HI = 3'h3,
    ST_ADDR_LO = 3'h2,
    ST_WDATA = 3'h6,
    ST_RDATA = 3'h7,
    ST_IGNORE = 3'h5
  } eep_state_t;

endpackage

//--- logic/eep_mem.sv
// simple dual-port byte memory with registered read data
// assumes one clock; contents start at the init value after configuration
`timescale 1ns/1ns
module eep_mem import eep_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter logic [DW-1:0] INIT = ERASED_BYTE
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // non-volatile contents survive system reset, so only the load value sets them
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = INIT;
    end
  end

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data always come from a register
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

//--- logic/eep_link_rx.sv
// serial line front end: bit capture on the serial clock, start and stop seen in the core domain
// assumes the serial clock pin drives link_scl and the sampled data pin stays stable while it is high
`timescale 1ns/1ns
module eep_link_rx import eep_pkg::*; (
  // core domain
  input wire logic core_clk,
  input wire logic sys_rst,
  // link pins
  input wire logic link_scl,
  input wire logic sda_in,
  // events for the engine
  output eep_line_ev_t line_ev
);

  logic val_ff;
  logic [1:0] in_s1_ff;
  logic [1:0] in_s2_ff;
  logic [1:0] in_s3_ff;

  // data bit taken on the rising serial clock; no reset here, the clock may stand still during reset
  always_ff @(posedge link_scl) begin
    val_ff <= sda_in;
  end

  // clock and data pass two flops; the third stage only feeds edge detection
  // reset to the released level of both lines so that no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_s1_ff <= '1;
      in_s2_ff <= '1;
      in_s3_ff <= '1;
    end else begin
      in_s1_ff <= {link_scl, sda_in};
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
    end
  end

  // start is data falling with clock high, stop is data rising with clock high
  assign line_ev.start = in_s2_ff[1] & in_s3_ff[1] & in_s3_ff[0] & ~in_s2_ff[0];
  assign line_ev.stop = in_s2_ff[1] & in_s3_ff[1] & ~in_s3_ff[0] & in_s2_ff[0];
  // the rise is seen two flops late, so val_ff has long settled and stands a whole clock period
  assign line_ev.bit_ev = in_s2_ff[1] & ~in_s3_ff[1];
  assign line_ev.bit_val = val_ff;
  assign line_ev.scl_fall = in_s3_ff[1] & ~in_s2_ff[1];

endmodule

//--- test/eep_engine_props.sv
// port checker for the eeprom engine: drive timing, programming window, protection
// assumes scl phases much longer than the few core cycles the front end needs
`timescale 1ns/1ns
module eep_engine_props import eep_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // bus and pins
  input wire logic LINK_SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic WP,
  input wire logic PROG_BUSY
);
  logic sda_q_ff;
  logic [7:0] since_stop_ff;
  int busy_cnt_ff;
  // cycles since a stop, saturating so an old stop never looks fresh
  always_ff @(posedge CORE_CLK) begin
    sda_q_ff <= SDA_IN;
    if (SYS_RST) since_stop_ff <= 8'hFF;
    else if (LINK_SCL && SDA_IN && !sda_q_ff) since_stop_ff <= 8'h00;
    else if (since_stop_ff != 8'hFF) since_stop_ff <= since_stop_ff + 8'h01;
  end
  // length of the running programming window
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || !PROG_BUSY) busy_cnt_ff <= 0;
    else busy_cnt_ff <= busy_cnt_ff + 1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  AST_OUT_LOW: assert property (SDA_OUT == 1'h0)
    else $error("open drain value not low");
  AST_BUSY_LEN: assert property ($fell(PROG_BUSY) |-> busy_cnt_ff >= PROG_CYCLES && busy_cnt_ff <= PROG_CYCLES + 1)
    else $error("programming window length wrong");
  AST_BUSY_QUIET: assert property (PROG_BUSY |-> SDA_OE_N)
    else $error("device drove line while programming");
  AST_BUSY_AT_STOP: assert property ($rose(PROG_BUSY) |-> since_stop_ff <= 8'h08)
    else $error("programming began without a stop");
  AST_WP_BLOCK: assert property ($rose(PROG_BUSY) |-> !$past(WP, 4))
    else $error("programming began while protected");
  AST_WP_NO_ABORT: assert property (PROG_BUSY && !$stable(WP) |-> ##1 PROG_BUSY [*4])
    else $error("protect change cut programming");
  AST_DRIVE_LOW_SCL: assert property ($fell(SDA_OE_N) |-> !LINK_SCL)
    else $error("device grabbed line with scl high");
  AST_HOLD_HIGH: assert property (LINK_SCL && $past(LINK_SCL) && !$rose(SDA_OE_N) |-> $stable(SDA_OE_N))
    else $error("device drive moved with scl high");
  AST_IDLE_RESET: assert property ($fell(SYS_RST) |-> SDA_OE_N && !PROG_BUSY)
    else $error("not idle after reset");
endmodule

bind eep_engine eep_engine_props #(.PROG_CYCLES(PROG_CYCLES)) eep_engine_props_inst (.CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST), .LINK_SCL(LINK_SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .WP(WP), .PROG_BUSY(PROG_BUSY));

//--- test/eep_host.sv
// behavioural bus host: drives scl and an open-drain data release, reads the resolved line
// assumes the bench resolves the wire with a pull-up; scl stands high between frames
`timescale 1ns/1ns
module eep_host (
  // link time base
  input wire logic lclk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic rel
);
  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    rel = 1'b1;
  end
  // one scl phase, long enough for the core front end
  task automatic wt();
    repeat (22) @(posedge lclk);
  endtask
  // start or repeated start: data falls while scl high
  task automatic start();
    rel <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    rel <= 1'b0;
    wt();
    scl <= 1'b0;
    repeat (3) @(posedge lclk);
  endtask
  // stop: data rises while scl high, then scl stays still
  task automatic stop();
    rel <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    rel <= 1'b1;
    wt();
  endtask
  // one clock; data moves only a few ticks after scl falls to keep hold time
  task automatic clk_bit(input logic b, output logic s);
    rel <= b;
    wt();
    scl <= 1'b1;
    wt();
    s = sda;
    scl <= 1'b0;
    repeat (3) @(posedge lclk);
  endtask
  // byte out msb first, line released on the ninth clock for the answer
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // byte in; host acknowledge asks for more, no-acknowledge ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!more, s);
  endtask
endmodule

//--- test/eep_engine_bench.sv
// self-checking bench for the eeprom engine with a behavioural bus host
// assumes a shortened programming window; straps tied to one select value except during the refusal check
`timescale 1ns/1ns
module eep_engine_bench;
  import eep_pkg::*;
  localparam int PROG = 3000;
  localparam logic [2:0] SEL = 3'h5;
  logic core_clk, sys_rst, lclk, wp, sda_out, sda_oe_n, busy, scl, rel;
  logic [2:0] sel;
  wire sda;
  int mismatches = 0;
  int n_compared = 0;
  // wired-and of both parties, pulled up when released
  assign sda = rel & (sda_oe_n | sda_out);
  eep_engine #(.PROG_CYCLES(PROG)) eep_engine_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK_SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .WP(wp), .CLIENT_SELECT_BIT2(sel[2]),
    .CLIENT_SELECT_BIT1(sel[1]), .CLIENT_SELECT_BIT0(sel[0]), .PROG_BUSY(busy));
  eep_host eep_host_inst (.lclk(lclk), .sda(sda), .scl(scl), .rel(rel));
  // core clock and an unrelated 15 ns link time base
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever begin
      #7 lclk = 1'b1;
      #8 lclk = 1'b0;
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {DEV_TYPE_CODE, SEL, rd};
  endfunction
  task automatic hdr(input logic [15:0] a);
    logic k1, k2, k3;
    eep_host_inst.start();
    eep_host_inst.send(dev(1'h0), k1);
    eep_host_inst.send(a[15:8], k2);
    eep_host_inst.send(a[7:0], k3);
    chk("header acks", {5'h00, k1, k2, k3}, 8'h07);
  endtask
  task automatic put(input logic [7:0] d);
    logic k;
    eep_host_inst.send(d, k);
    chk("data ack", {7'h00, k}, 8'h01);
  endtask
  task automatic wr1(input logic [15:0] a, input logic [7:0] d);
    hdr(a);
    put(d);
    eep_host_inst.stop();
  endtask
  // read open; random reads load the address first with a dummy write
  task automatic rd_open(input logic [15:0] a, input logic random);
    logic k;
    if (random) hdr(a);
    eep_host_inst.start();
    eep_host_inst.send(dev(1'h1), k);
    chk("read ack", {7'h00, k}, 8'h01);
  endtask
  task automatic get(input logic more, input logic [7:0] exp);
    logic [7:0] d;
    eep_host_inst.recv(more, d);
    chk("read data", d, exp);
    if (!more) eep_host_inst.stop();
  endtask
  task automatic poll(input logic exp);
    logic k;
    eep_host_inst.start();
    eep_host_inst.send(dev(1'h0), k);
    eep_host_inst.stop();
    chk("poll ack", {7'h00, k}, {7'h00, exp});
  endtask
  // bounded wait for the programming window to close
  task automatic settle();
    int i;
    i = 0;
    repeat (10) @(posedge core_clk);
    while (busy !== 1'b0 && i < PROG + 20) begin
      @(posedge core_clk);
      i++;
    end
    chk("busy end", {7'h00, busy}, 8'h00);
  endtask
  task automatic busy_is(input logic exp);
    repeat (10) @(posedge core_clk);
    chk("busy", {7'h00, busy}, {7'h00, exp});
  endtask
  task automatic s_erased();
    logic k;
    logic [7:0] bad [2] = '{8'hA4, 8'hBA};
    chk("idle pins", {6'h00, sda_oe_n, busy}, 8'h02);
    rd_open(16'h4321, 1'h1);
    get(1'h0, ERASED_BYTE);
    for (int i = 0; i < 2; i++) begin
      eep_host_inst.start();
      eep_host_inst.send(bad[i], k);
      eep_host_inst.stop();
      chk("foreign byte", {7'h00, k}, 8'h00);
    end
    // other strap setting: our own select value must now be refused
    @(posedge core_clk);
    sel <= 3'h2;
    repeat (5) @(posedge core_clk);
    poll(1'h0);
    sel <= SEL;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic s_byte();
    wr1(16'h1234, 8'h5A);
    busy_is(1'h1);
    poll(1'h0);
    settle();
    poll(1'h1);
    rd_open(16'h1234, 1'h1);
    get(1'h0, 8'h5A);
    rd_open(16'h0000, 1'h0);
    get(1'h0, 8'hFF);
  endtask
  // page load crossing the page end wraps inside the row
  task automatic s_page();
    hdr(16'h02FE);
    put(8'h11);
    put(8'h22);
    put(8'h33);
    eep_host_inst.stop();
    settle();
    rd_open(16'h02FE, 1'h1);
    get(1'h1, 8'h11);
    get(1'h1, 8'h22);
    get(1'h0, 8'hFF);
    rd_open(16'h0280, 1'h1);
    get(1'h0, 8'h33);
  endtask
  task automatic s_protect();
    @(posedge core_clk);
    wp <= 1'h1;
    wr1(16'h0010, 8'h77);
    busy_is(1'h0);
    poll(1'h1);
    @(posedge core_clk);
    wp <= 1'h0;
    wr1(16'h0011, 8'h66);
    repeat (20) @(posedge core_clk);
    wp <= 1'h1;
    settle();
    @(posedge core_clk);
    wp <= 1'h0;
    rd_open(16'h0010, 1'h1);
    get(1'h1, 8'hFF);
    get(1'h0, 8'h66);
  endtask
  task automatic s_wrap();
    wr1(16'h0000, 8'hC3);
    settle();
    hdr(16'hFFFF);
    eep_host_inst.stop();
    busy_is(1'h0);
    rd_open(16'h0000, 1'h0);
    get(1'h1, 8'hFF);
    get(1'h0, 8'hC3);
  endtask
  // watchdog against a hung handshake
  initial begin
    #900000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    wp = 1'b0;
    sel = SEL;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    s_erased();
    s_byte();
    s_page();
    s_protect();
    s_wrap();
    report_and_stop();
  end
endmodule
